// File: core/ptdfm_top.sv
// periodic tick timer with binary/decimal prescaler and pll frequency
// modulation control, behind a 32-bit apb slave.
// assumes all inputs are synchronous to pclk; the tick source clocks and
// the pll reference arrive as one-cycle enable pulses.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - fm register: amplitude bits 5:4, rest zero
// - fm write needs protect clear, pll select set
// - accepted fm write clears lock and osc-up
// - amplitude codes: off, 1, 2, 4 percent
// - modulation rate is reference divided by 16
// - tick source: rc clock or oscillator clock
// - stop halts counter unless pseudo-stop on oscillator
// - tick register writable anytime, unprotected
// - tick register write restarts timeout period
// - source select change restarts timeout period
// - bit 7 picks binary or decimal prescale
// - binary codes: off, then 2^10 to 2^16
// - modulus field multiplies prescale by value+1
// - binary code zero: timer off, no timeouts
// - decimal codes: 1k to 200k divides
// - interrupt request when flag and enable set
// - osc loss clears source select; set needs osc
module ptdfm_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irc_tick_in,
   input wire logic osc_tick_in,
   input wire logic ref_tick_in,
   input wire logic osc_ok_in,
   input wire logic pll_lock_in,
   input wire logic stop_mode_in,
   output logic tick_irq_out,
   output logic tick_source_select_out,
   output logic oscillator_up_status_out,
   output logic fm_enable_out,
   output logic [2:0] fm_spread_pct_out,
   output logic fm_mod_wave_out
);

   // ==========================================================
   // state registers and decode
   ptdfm_pkg::ptdfm_state_type st_ff;
   ptdfm_pkg::ptdfm_state_type nxt_st;

   logic acc_phase;
   logic setup_phase;
   logic addr_aligned;
   logic hit_fm;
   logic hit_tick;
   logic hit_cfg;
   logic hit_sts;
   logic mapped;
   logic wr_ok;
   logic fm_wr;
   logic tick_wr;
   logic cfg_wr;
   logic sts_wr;
   logic tick_restart;
   logic src_tick;
   logic tick_off;
   logic tick_run;
   logic pre_last;
   logic mod_last;
   logic timeout;
   logic fm_on;
   logic [17:0] presc;
   logic [31:0] rd_mux;

   // apb phase and address decode; misaligned addresses are unmapped
   assign acc_phase = psel & penable;
   assign setup_phase = psel & ~penable;
   assign addr_aligned = (paddr[1:0] == 2'h0);
   assign hit_fm = addr_aligned & (paddr[11:2] == ptdfm_pkg::PTDFM_IDX_PLL_FM);
   assign hit_tick = addr_aligned & (paddr[11:2] == ptdfm_pkg::PTDFM_IDX_TICK);
   assign hit_cfg = addr_aligned & (paddr[11:2] == ptdfm_pkg::PTDFM_IDX_CFG);
   assign hit_sts = addr_aligned & (paddr[11:2] == ptdfm_pkg::PTDFM_IDX_STS);
   assign mapped = hit_fm | hit_tick | hit_cfg | hit_sts;
   // only byte lane 0 carries register bits
   assign wr_ok = acc_phase & pwrite & pstrb[0];
   assign fm_wr = wr_ok & hit_fm & ~st_ff.wprot & st_ff.pll_sel;
   assign tick_wr = wr_ok & hit_tick;
   assign cfg_wr = wr_ok & hit_cfg;
   assign sts_wr = wr_ok & hit_sts;

   // tick counter controls, from the registered tick byte, config bits and the stop input
   assign src_tick = st_ff.src_sel ? osc_tick_in : irc_tick_in;
   assign presc = ptdfm_pkg::ptdfm_prescale(
      st_ff.tick_ctrl[ptdfm_pkg::PTDFM_TICK_DEC_BIT],
      st_ff.tick_ctrl[ptdfm_pkg::PTDFM_TICK_PRE_MSB:ptdfm_pkg::PTDFM_TICK_PRE_LSB]);
   assign tick_off = (presc == 18'h00000);
   // stop halts the count; only pseudo-stop on the oscillator keeps it alive
   assign tick_run = ~tick_off & (~stop_mode_in | (st_ff.pstop & st_ff.src_sel));
   assign pre_last = (st_ff.pre_cnt == (presc - 18'h00001));
   assign mod_last = (st_ff.mod_cnt ==
      st_ff.tick_ctrl[ptdfm_pkg::PTDFM_TICK_MOD_MSB:ptdfm_pkg::PTDFM_TICK_MOD_LSB]);
   assign fm_on = (st_ff.fm_amp != 2'h0);

   // read data multiplexer; unmapped reads give zero
   always_comb begin
      rd_mux = 32'h00000000;
      if (hit_fm) begin
         rd_mux = {26'h0, st_ff.fm_amp, 4'h0};
      end else if (hit_tick) begin
         rd_mux = {24'h0, st_ff.tick_ctrl};
      end else if (hit_cfg) begin
         rd_mux = {27'h0, st_ff.irq_en, st_ff.wprot, st_ff.pll_sel, st_ff.pstop,
            st_ff.src_sel};
      end else if (hit_sts) begin
         rd_mux = {29'h0, st_ff.pll_lock, st_ff.osc_up, st_ff.flag};
      end
   end

   // ==========================================================
   // next-state logic
   always_comb begin
      nxt_st = st_ff;
      tick_restart = 1'b0;
      timeout = 1'b0;
      // status bits follow their inputs; the documented write clear wins
      nxt_st.osc_up = fm_wr ? 1'b0 : osc_ok_in;
      nxt_st.pll_lock = fm_wr ? 1'b0 : pll_lock_in;
      if (fm_wr) begin
         nxt_st.fm_amp = pwdata[ptdfm_pkg::PTDFM_FM_AMP_MSB:ptdfm_pkg::PTDFM_FM_AMP_LSB];
      end
      if (cfg_wr) begin
         nxt_st.src_sel = pwdata[ptdfm_pkg::PTDFM_CFG_SRC_BIT];
         nxt_st.pstop = pwdata[ptdfm_pkg::PTDFM_CFG_PSTOP_BIT];
         nxt_st.pll_sel = pwdata[ptdfm_pkg::PTDFM_CFG_PLL_CLOCK_SELECT_BIT];
         nxt_st.wprot = pwdata[ptdfm_pkg::PTDFM_CFG_WPROT_BIT];
         nxt_st.irq_en = pwdata[ptdfm_pkg::PTDFM_CFG_IRQEN_BIT];
      end
      // source select survives only while the oscillator is up
      nxt_st.src_sel = nxt_st.src_sel & nxt_st.osc_up;
      if (tick_wr) begin
         nxt_st.tick_ctrl = pwdata[7:0];
      end
      // a restart wipes the count before any tick is counted
      tick_restart = tick_wr | (nxt_st.src_sel != st_ff.src_sel);
      timeout = tick_run & src_tick & pre_last & mod_last & ~tick_restart;
      if (tick_restart) begin
         nxt_st.pre_cnt = 18'h00000;
         nxt_st.mod_cnt = 4'h0;
      end else if (tick_run & src_tick) begin
         if (pre_last) begin
            nxt_st.pre_cnt = 18'h00000;
            nxt_st.mod_cnt = mod_last ? 4'h0 : (st_ff.mod_cnt + 4'h1);
         end else begin
            nxt_st.pre_cnt = st_ff.pre_cnt + 18'h00001;
         end
      end
      // timeout set beats a software clear in the same cycle
      if (timeout) begin
         nxt_st.flag = 1'b1;
      end else if (sts_wr & pwdata[ptdfm_pkg::PTDFM_STS_FLAG_BIT]) begin
         nxt_st.flag = 1'b0;
      end
      // modulation wave: high for the upper half of a 16-tick reference cycle
      if (!fm_on) begin
         nxt_st.fm_div = 4'h0;
         nxt_st.fm_wave = 1'b0;
      end else if (ref_tick_in) begin
         nxt_st.fm_div = st_ff.fm_div + 4'h1;
         nxt_st.fm_wave = nxt_st.fm_div[3];
      end
      // read data is captured in the setup cycle so prdata comes from a flop
      if (setup_phase) begin
         nxt_st.prdata = rd_mux;
      end
   end

   // single register stage for the whole state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= ptdfm_pkg::PTDFM_STATE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // outputs
   assign prdata = st_ff.prdata;
   assign pready = 1'b1; // zero wait states
   assign pslverr = acc_phase & ~mapped;
   assign tick_irq_out = st_ff.flag & st_ff.irq_en;
   assign tick_source_select_out = st_ff.src_sel;
   assign oscillator_up_status_out = st_ff.osc_up;
   assign fm_enable_out = fm_on;
   assign fm_mod_wave_out = st_ff.fm_wave;

   // amplitude decode in percent of vco frequency
   always_comb begin
      case (st_ff.fm_amp)
         2'h0: fm_spread_pct_out = 3'h0;
         2'h1: fm_spread_pct_out = 3'h1;
         2'h2: fm_spread_pct_out = 3'h2;
         default: fm_spread_pct_out = 3'h4;
      endcase
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence seq_fm_write;
      fm_wr;
   endsequence

   sequence seq_status_dropped;
      !st_ff.osc_up && !st_ff.pll_lock;
   endsequence

   sequence seq_count_zero;
      st_ff.pre_cnt == 18'h00000 && st_ff.mod_cnt == 4'h0;
   endsequence

   pll_rsvd_zero_a: assert property (
      acc_phase && hit_fm && !pwrite |-> prdata[31:6] == 26'h0 && prdata[3:0] == 4'h0)
      else $error("reserved fm register bits read nonzero");

   fm_wr_block_a: assert property (
      wr_ok && hit_fm && (st_ff.wprot || !st_ff.pll_sel) |=> $stable(st_ff.fm_amp))
      else $error("blocked fm write changed amplitude");

   fm_wr_clear_a: assert property (
      seq_fm_write |=> seq_status_dropped)
      else $error("fm write did not clear status bits");

   fm_amp_max_a: assert property (
      st_ff.fm_amp == 2'h3 |-> fm_spread_pct_out == 3'h4 && fm_enable_out)
      else $error("top amplitude code not four percent");

   fm_wave_rate_a: assert property (
      fm_on && ref_tick_in && st_ff.fm_div == ptdfm_pkg::PTDFM_FM_DIV_LAST
      |=> !fm_mod_wave_out && st_ff.fm_div == 4'h0)
      else $error("modulation wave period wrong");

   fm_wave_high_a: assert property (
      fm_on && ref_tick_in && st_ff.fm_div == ptdfm_pkg::PTDFM_FM_HALF_LAST
      |=> fm_mod_wave_out)
      else $error("modulation wave did not rise at half period");

   src_needs_osc_a: assert property (
      st_ff.src_sel |-> st_ff.osc_up)
      else $error("tick source on oscillator while oscillator down");

   stop_hold_a: assert property (
      stop_mode_in && !(st_ff.pstop && st_ff.src_sel) && !tick_restart
      |=> $stable(st_ff.pre_cnt) && $stable(st_ff.mod_cnt))
      else $error("tick counter moved in stop mode");

   tick_wr_restart_a: assert property (
      tick_wr |=> seq_count_zero)
      else $error("tick register write did not restart period");

   src_chg_restart_a: assert property (
      $changed(st_ff.src_sel) |-> seq_count_zero)
      else $error("source change did not restart period");

   bin_off_a: assert property (
      !st_ff.tick_ctrl[7] && st_ff.tick_ctrl[6:4] == 3'h0 |=> !$rose(st_ff.flag))
      else $error("timeout raised while timer off");

   irq_gate_a: assert property (
      $rose(st_ff.flag) && st_ff.irq_en |-> tick_irq_out ##1 (tick_irq_out || !st_ff.flag))
      else $error("tick interrupt not requested");

   timeout_wrap_a: assert property (
      timeout |=> st_ff.flag and seq_count_zero)
      else $error("timeout did not set flag and restart");

endmodule

`default_nettype wire

// File: core/ptdfm_pkg.sv
// constants, state layout and prescale table for the periodic tick divider
// and pll frequency modulation control block.
// assumes a 32-bit apb slave with word-aligned registers.
package ptdfm_pkg;

   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [9:0] PTDFM_IDX_PLL_FM = 10'h03a;
   localparam logic [9:0] PTDFM_IDX_TICK = 10'h03b;
   localparam logic [9:0] PTDFM_IDX_CFG = 10'h040;
   localparam logic [9:0] PTDFM_IDX_STS = 10'h041;

   // ==========================================================
   // field positions
   localparam int PTDFM_FM_AMP_LSB = 4;
   localparam int PTDFM_FM_AMP_MSB = 5;
   localparam int PTDFM_TICK_DEC_BIT = 7;
   localparam int PTDFM_TICK_PRE_LSB = 4;
   localparam int PTDFM_TICK_PRE_MSB = 6;
   localparam int PTDFM_TICK_MOD_LSB = 0;
   localparam int PTDFM_TICK_MOD_MSB = 3;
   localparam int PTDFM_CFG_SRC_BIT = 0;
   localparam int PTDFM_CFG_PSTOP_BIT = 1;
   localparam int PTDFM_CFG_PLL_CLOCK_SELECT_BIT = 2;
   localparam int PTDFM_CFG_WPROT_BIT = 3;
   localparam int PTDFM_CFG_IRQEN_BIT = 4;
   localparam int PTDFM_STS_FLAG_BIT = 0;

   // ==========================================================
   // reset values and fixed counts
   localparam logic [1:0] PTDFM_FM_AMP_RST = 2'h0;
   localparam logic [7:0] PTDFM_TICK_RST = 8'h00;
   localparam logic PTDFM_PLL_CLOCK_SELECT_RST = 1'b1;
   localparam int PTDFM_FM_REF_DIV = 16;
   localparam logic [3:0] PTDFM_FM_HALF_LAST = 4'h7;
   localparam logic [3:0] PTDFM_FM_DIV_LAST = 4'hf;

   // ==========================================================
   // state of the block, registered as one word
   typedef struct packed {
      logic [1:0] fm_amp;
      logic [7:0] tick_ctrl;
      logic src_sel;
      logic pstop;
      logic pll_sel;
      logic wprot;
      logic irq_en;
      logic flag;
      logic osc_up;
      logic pll_lock;
      logic [17:0] pre_cnt;
      logic [3:0] mod_cnt;
      logic [3:0] fm_div;
      logic fm_wave;
      logic [31:0] prdata;
   } ptdfm_state_type;

   localparam ptdfm_state_type PTDFM_STATE_RST = '{
      fm_amp: PTDFM_FM_AMP_RST,
      tick_ctrl: PTDFM_TICK_RST,
      src_sel: 1'b0,
      pstop: 1'b0,
      pll_sel: PTDFM_PLL_CLOCK_SELECT_RST,
      wprot: 1'b0,
      irq_en: 1'b0,
      flag: 1'b0,
      osc_up: 1'b0,
      pll_lock: 1'b0,
      pre_cnt: 18'h00000,
      mod_cnt: 4'h0,
      fm_div: 4'h0,
      fm_wave: 1'b0,
      prdata: 32'h00000000
   };

   // ==========================================================
   // prescale divide; zero means the timer is off
   function automatic logic [17:0] ptdfm_prescale(input logic dec, input logic [2:0] code);
      logic [17:0] r;
      r = 18'h00000;
      if (dec) begin
         case (code)
            3'h0: r = 18'h003e8;
            3'h1: r = 18'h007d0;
            3'h2: r = 18'h01388;
            3'h3: r = 18'h02710;
            3'h4: r = 18'h04e20;
            3'h5: r = 18'h0c350;
            3'h6: r = 18'h186a0;
            default: r = 18'h30d40;
         endcase
      end else begin
         case (code)
            3'h0: r = 18'h00000;
            3'h1: r = 18'h00400;
            3'h2: r = 18'h00800;
            3'h3: r = 18'h01000;
            3'h4: r = 18'h02000;
            3'h5: r = 18'h04000;
            3'h6: r = 18'h08000;
            default: r = 18'h10000;
         endcase
      end
      return r;
   endfunction

endpackage

// File: tb/ptdfm_top_tb.sv
// self-checking bench for the periodic tick divider and fm control block.
// assumes the apb slave answers in one access cycle and that the bench
// itself stands in for the rc, oscillator and reference tick sources.
`timescale 1ns/10ps
`default_nettype none

module ptdfm_top_tb;
   // ==========================================================
   // byte addresses: four times the register index
   localparam logic [11:0] A_FM = {ptdfm_pkg::PTDFM_IDX_PLL_FM, 2'b00};
   localparam logic [11:0] A_TK = {ptdfm_pkg::PTDFM_IDX_TICK, 2'b00};
   localparam logic [11:0] A_CF = {ptdfm_pkg::PTDFM_IDX_CFG, 2'b00};
   localparam logic [11:0] A_ST = {ptdfm_pkg::PTDFM_IDX_STS, 2'b00};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, err_seen, osc_after_wr, tick_irq, src_out, osc_up, fm_en, fm_wave;
   logic [2:0] fm_pct;
   logic irc_tick = 1'b1, osc_tick = 1'b0, ref_tick = 1'b1;
   logic osc_ok = 1'b1, lock_in = 1'b1, stop_mode = 1'b0;
   int error_cnt = 0, checks_done = 0;

   ptdfm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irc_tick_in(irc_tick), .osc_tick_in(osc_tick),
      .ref_tick_in(ref_tick), .osc_ok_in(osc_ok), .pll_lock_in(lock_in),
      .stop_mode_in(stop_mode), .tick_irq_out(tick_irq), .tick_source_select_out(src_out),
      .oscillator_up_status_out(osc_up), .fm_enable_out(fm_en),
      .fm_spread_pct_out(fm_pct), .fm_mod_wave_out(fm_wave));

   // ==========================================================
   // clock and verdict
   initial begin
      forever #5 pclk = ~pclk;
   end

   task end_sim();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         error_cnt++;
      end
   endtask

   // ==========================================================
   // apb master: entered right after a rising edge, leaves one idle cycle
   // so no signal is assigned twice in one time step
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && i < 20) begin
         @(posedge pclk);
         i++;
      end
      if (i >= 20) begin
         error_cnt++;
         end_sim();
      end
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1 osc_after_wr = osc_up;
      @(posedge pclk);
   endtask

   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(rd, exp);
   endtask

   // set config, clear the flag, then restart the period with a tick write
   task start_tick(input logic [7:0] cfg, input logic [7:0] tk);
      apb(1'b1, A_CF, {24'h000000, cfg});
      apb(1'b1, A_ST, 32'h00000001);
      apb(1'b1, A_TK, {24'h000000, tk});
   endtask

   // edges until the request rises must fall in exp .. exp+slack
   // sampled on the falling edge, returns right after a rising edge
   task wait_tick(input int exp, input int slack);
      int n;
      logic found;
      n = 1; // the idle edge after the restarting write already counted a pulse
      found = 1'b0;
      while (!found && n <= exp + slack) begin
         @(negedge pclk);
         found = (tick_irq === 1'b1);
         @(posedge pclk);
         if (!found) begin
            n++;
         end
      end
      chk(32'(n >= exp && n <= exp + slack), 32'h00000001);
   endtask

   int div_tab[7] = '{1024, 2048, 4096, 16384, 1000, 2000, 5000};
   logic [7:0] code_tab[7] = '{8'h10, 8'h20, 8'h30, 8'h1f, 8'h80, 8'h81, 8'ha0};
   logic [2:0] pct_tab[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
   int n;
   logic prev;

   // ==========================================================
   // main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(A_FM, 32'h00000000);
      rd_chk(A_TK, 32'h00000000);
      rd_chk(A_CF, 32'h00000004);
      rd_chk(12'h0f0, 32'h00000000);
      chk(err_seen, 1'b1);
      // every amplitude code; other bits written as ones read zero
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, A_FM, 32'hffffffcf | (c << 4));
         chk(osc_after_wr, 1'b0);
         rd_chk(A_FM, c << 4);
         chk(fm_pct, pct_tab[c]);
         chk(fm_en, 32'(c != 0));
      end
      // modulation period: rise to rise with a reference tick each cycle
      n = 0;
      prev = 1'b1;
      while (n < 60 && !(prev === 1'b0 && fm_wave === 1'b1)) begin
         prev = fm_wave;
         @(posedge pclk);
         #1 n++;
      end
      n = 0;
      prev = 1'b1;
      while (n < 60 && !(prev === 1'b0 && fm_wave === 1'b1)) begin
         prev = fm_wave;
         @(posedge pclk);
         #1 n++;
      end
      chk(n, 16);
      @(posedge pclk);
      // refused fm writes: protect set, then pll select clear
      apb(1'b1, A_CF, 32'h0000000c);
      apb(1'b1, A_FM, 32'h00000010);
      chk(osc_after_wr, 1'b1);
      apb(1'b1, A_CF, 32'h00000000);
      apb(1'b1, A_FM, 32'h00000010);
      rd_chk(A_FM, 32'h00000030);
      apb(1'b1, A_TK, 32'h0000005a);
      rd_chk(A_TK, 32'h0000005a);
      // divide table: binary and decimal families with modulus
      for (int k = 0; k < 7; k++) begin
         start_tick(8'h14, code_tab[k]);
         wait_tick(div_tab[k], 1);
      end
      // flag is kept while enable is off, request follows enable
      apb(1'b1, A_CF, 32'h00000004);
      chk(tick_irq, 1'b0);
      rd_chk(A_ST, 32'h00000007);
      apb(1'b1, A_CF, 32'h00000014);
      chk(tick_irq, 1'b1);
      // binary code zero stays silent, tried here with modulus 15 only
      start_tick(8'h14, 8'h0f);
      repeat (3000) @(posedge pclk);
      chk(tick_irq, 1'b0);
      // rewrite in mid-period restarts the count
      start_tick(8'h14, 8'h10);
      repeat (600) @(posedge pclk);
      apb(1'b1, A_TK, 32'h00000010);
      wait_tick(1024, 1);
      // stop mode on the rc source halts and holds the count
      start_tick(8'h14, 8'h10);
      repeat (500) @(posedge pclk);
      stop_mode <= 1'b1;
      repeat (1000) @(posedge pclk);
      stop_mode <= 1'b0;
      wait_tick(522, 3);
      // oscillator source under pseudo-stop keeps running, rc is ignored
      osc_tick <= 1'b1;
      irc_tick <= 1'b0;
      start_tick(8'h17, 8'h10);
      chk(src_out, 1'b1);
      stop_mode <= 1'b1;
      wait_tick(1022, 3);
      stop_mode <= 1'b0;
      // oscillator loss forces the rc source and restarts the period
      irc_tick <= 1'b1;
      start_tick(8'h15, 8'h10);
      repeat (500) @(posedge pclk);
      osc_ok <= 1'b0;
      @(posedge pclk);
      wait_tick(1024, 3);
      chk(src_out, 1'b0);
      apb(1'b1, A_CF, 32'h00000005);
      rd_chk(A_CF, 32'h00000004);
      end_sim();
   end

   // hang guard
   initial begin
      #900000;
      error_cnt++;
      end_sim();
   end
endmodule

`default_nettype wire
